/* design/ors_top.sv */
/*
 * output ramp sequencer: run line, shared time base, delayed digital
 * soft-start, servo hand-over, soft-off and fault three-state.
 * assumes synchronous inputs, open-drain run/time-base lines resolved
 * outside, and an analog loop that follows o_dac.
 */
// Functional notes
// - run line held low until initialised and input above turn-on.
// - every sharer holds shared run line low until it is ready.
// - after run release count turn-on delay; soft-start only from run.
// - timing from shared time base; fastest clock on line governs.
// - soft-start steps target from zero up to commanded set point.
// - rise time under a quarter millisecond skips the ramp.
// - ramp has rise/0.1 ms steps, one step per tick.
// - discontinuous conduction throughout the rising ramp.
// - in discontinuous mode low-side gate off on reverse current.
// - rise time capped at 1.3 seconds.
// - power good filtered 60 us before reaching its pin.
// - servo only while mode bit 6 (servo bit) is set.
// - servo moves dac one lsb toward target every 90 ms.
// - zero max limit: servo after ramp and output above uv limit.
// - at servo start leave discontinuous, adopt mode bit 0.
// - limit set, ignore response: ramp, limit, and no uv or no oc.
// - limit set, other response: ramp, limit, no uv and no oc.
// - fall sequence on run line low or serial turn-off.
// - fault or enabled external fault line three-states at once.
// - fall time capped at 1.3 s, fall/0.1 ms steps.
// - at end of fall stop sinking current.
// - input below turn-off pulls time base low until above turn-on.
`timescale 1ns/100ps
module ors_top #(
	parameter int unsigned TICK_CYC = ors_pkg::TICK_CYC,
	parameter int unsigned PG_CYC = ors_pkg::PG_FILT_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [ors_pkg::ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_init_done,
	input wire ors_pkg::ors_sense_t i_sense,
	input wire logic i_run_line,
	output logic o_run_line,
	output logic o_run_line_oe,
	input wire logic i_time_base,
	output logic o_time_base,
	output logic o_time_base_oe,
	input wire logic i_fault_line_n,
	input wire logic i_reverse_current,
	input wire logic i_power_good_raw,
	output logic o_power_good_out,
	output logic [ors_pkg::DAC_W-1:0] o_dac,
	output logic o_dcm,
	output logic o_low_gate_en,
	output logic o_stage_en,
	output logic o_sink_en,
	output logic o_range_fine
);
	localparam int unsigned TW = ors_pkg::TIME_W;
	localparam int unsigned DW = ors_pkg::DAC_W;
	localparam logic [TW-1:0] CAP = TW'(ors_pkg::RAMP_MAX_TICKS);

	if (TICK_CYC < 3 || TICK_CYC > 65535) begin : g_bad_tick
		$error("tick divider out of range");
	end
	if (PG_CYC < 2 || PG_CYC > 65535) begin : g_bad_pg
		$error("power good filter out of range");
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	ors_pkg::ors_cfg_t cfg_q;
	ors_pkg::ors_state_t st_q;
	logic [TW-1:0] cnt_q, lim_q, rise_n, fall_n;
	logic [15:0] div_q, pg_cnt_q;
	logic [ors_pkg::SRV_W-1:0] srv_q;
	logic [DW-1:0] dac_q, base_q, ramp;
	logic [DW+TW-1:0] prod;
	logic [TW-1:0] num, den;
	logic [31:0] rdata_q, rsel;
	logic lockout_q, hold_q, pull_q, tb_prev_q, pg_q;
	logic tick, flt, off_req, active, servo_en, servo_go, lim_hit;
	logic rise_skip, srv_step;

	// shared lines are open drain: only ever pulled low
	assign o_run_line = 1'b0;
	assign o_time_base = 1'b0;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			lockout_q <= 1'b1;
		end else if (i_ce) begin
			if (i_sense.vin_below_off) begin
				lockout_q <= 1'b1;
			end else if (i_sense.vin_above_on) begin
				lockout_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			hold_q <= 1'b1;
		end else if (i_ce) begin
			hold_q <= !i_init_done || lockout_q;
		end
	end
	assign o_run_line_oe = hold_q;

	a_run_hold: assert property (
		i_ce && !i_init_done |=> o_run_line_oe)
		else $error("run line released before init");

	// own divider pulses the line; any falling edge, ours or a faster
	// partner's, is the tick and restarts the divider
	assign tick = tb_prev_q && !i_time_base;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			div_q <= 16'h0000;
			pull_q <= 1'b0;
			// lockout holds the line low in reset: no false tick on release
			tb_prev_q <= 1'b0;
		end else if (i_ce) begin
			tb_prev_q <= i_time_base;
			pull_q <= div_q == 16'(TICK_CYC - 2);
			if (tick) begin
				div_q <= 16'h0000;
			end else if (div_q != 16'(TICK_CYC - 1)) begin
				div_q <= div_q + 16'h0001;
			end
		end
	end
	assign o_time_base_oe = pull_q || lockout_q;

	a_tb_lock: assert property (
		i_ce && i_sense.vin_below_off ##1 !i_sense.vin_above_on
		|-> o_time_base_oe [*2])
		else $error("time base not held low in lockout");

	// register port
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cfg_q <= '{ctrl: ors_pkg::CTRL_RST, mode: ors_pkg::MODE_RST,
				ton_delay: ors_pkg::TIME_RST, ton_rise: ors_pkg::TIME_RST,
				ton_max: ors_pkg::TIME_RST,
				ton_max_resp: ors_pkg::RESP_IGNORE,
				toff_delay: ors_pkg::TIME_RST,
				toff_fall: ors_pkg::TIME_RST, vout: ors_pkg::VOUT_RST};
		end else if (i_ce && i_wr) begin
			case (i_addr)
			ors_pkg::ADDR_CTRL: cfg_q.ctrl <= i_wdata[1:0];
			ors_pkg::ADDR_MODE: cfg_q.mode <= i_wdata[7:0];
			ors_pkg::ADDR_TON_DELAY: cfg_q.ton_delay <= i_wdata[TW-1:0];
			ors_pkg::ADDR_TON_RISE: cfg_q.ton_rise <= i_wdata[TW-1:0];
			ors_pkg::ADDR_TON_MAX: cfg_q.ton_max <= i_wdata[TW-1:0];
			ors_pkg::ADDR_TON_MAX_RESP: cfg_q.ton_max_resp <= i_wdata[7:0];
			ors_pkg::ADDR_TOFF_DELAY: cfg_q.toff_delay <= i_wdata[TW-1:0];
			ors_pkg::ADDR_TOFF_FALL: cfg_q.toff_fall <= i_wdata[TW-1:0];
			ors_pkg::ADDR_VOUT: cfg_q.vout <= i_wdata[DW-1:0];
			default: ;
			endcase
		end
	end

	always_comb begin
		case (i_addr)
		ors_pkg::ADDR_CTRL: rsel = {30'h0, cfg_q.ctrl};
		ors_pkg::ADDR_MODE: rsel = {24'h0, cfg_q.mode};
		ors_pkg::ADDR_TON_DELAY: rsel = {16'h0, cfg_q.ton_delay};
		ors_pkg::ADDR_TON_RISE: rsel = {16'h0, cfg_q.ton_rise};
		ors_pkg::ADDR_TON_MAX: rsel = {16'h0, cfg_q.ton_max};
		ors_pkg::ADDR_TON_MAX_RESP: rsel = {24'h0, cfg_q.ton_max_resp};
		ors_pkg::ADDR_TOFF_DELAY: rsel = {16'h0, cfg_q.toff_delay};
		ors_pkg::ADDR_TOFF_FALL: rsel = {16'h0, cfg_q.toff_fall};
		ors_pkg::ADDR_VOUT: rsel = {20'h0, cfg_q.vout};
		ors_pkg::ADDR_STATUS: rsel = {25'h0, st_q, pg_q, i_run_line,
			lockout_q, o_dcm};
		ors_pkg::ADDR_DAC: rsel = {20'h0, dac_q};
		default: rsel = 32'h0000_0000;
		endcase
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_ce) begin
			rdata_q <= i_rd ? rsel : 32'h0000_0000;
		end
	end
	assign o_rdata = rdata_q;

	// sequencing conditions
	assign flt = i_sense.fault ||
		(!i_fault_line_n && cfg_q.ctrl[ors_pkg::CTRL_FLT_RESP_BIT]);
	assign off_req = !i_run_line ||
		!cfg_q.ctrl[ors_pkg::CTRL_OP_BIT];
	assign active = st_q != ors_pkg::ORS_OFF && st_q != ors_pkg::ORS_HIZ;
	assign rise_n = cfg_q.ton_rise > CAP ? CAP : cfg_q.ton_rise;
	assign fall_n = cfg_q.toff_fall > CAP ? CAP : cfg_q.toff_fall;
	assign rise_skip = rise_n < TW'(ors_pkg::RISE_MIN_TICKS);
	assign lim_hit = lim_q >= cfg_q.ton_max;

	always_comb begin
		if (cfg_q.ton_max == ors_pkg::TIME_RST) begin
			servo_go = !i_sense.uv_fault;
		end else if (cfg_q.ton_max_resp == ors_pkg::RESP_IGNORE) begin
			servo_go = lim_hit &&
				(!i_sense.uv_fault || !i_sense.oc_active);
		end else begin
			servo_go = lim_hit &&
				!i_sense.uv_fault && !i_sense.oc_active;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_q <= ors_pkg::ORS_OFF;
			cnt_q <= '0;
		end else if (i_ce) begin
			if (active && flt) begin
				st_q <= ors_pkg::ORS_HIZ;
				cnt_q <= '0;
			end else begin
				case (st_q)
				ors_pkg::ORS_OFF: begin
					cnt_q <= '0;
					if (!off_req && !flt && !lockout_q) begin
						st_q <= ors_pkg::ORS_DLY;
					end
				end
				ors_pkg::ORS_DLY: begin
					if (off_req) begin
						st_q <= ors_pkg::ORS_OFF;
					end else if (cnt_q == cfg_q.ton_delay) begin
						st_q <= ors_pkg::ORS_RISE;
						cnt_q <= '0;
					end else if (tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ors_pkg::ORS_RISE: begin
					if (off_req) begin
						st_q <= ors_pkg::ORS_TOFF;
						cnt_q <= '0;
					end else if (rise_skip || cnt_q == rise_n) begin
						st_q <= ors_pkg::ORS_WAIT;
					end else if (tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ors_pkg::ORS_WAIT: begin
					cnt_q <= '0;
					if (off_req) begin
						st_q <= ors_pkg::ORS_TOFF;
					end else if (servo_go) begin
						st_q <= ors_pkg::ORS_ON;
					end
				end
				ors_pkg::ORS_ON: begin
					cnt_q <= '0;
					if (off_req) begin
						st_q <= ors_pkg::ORS_TOFF;
					end
				end
				ors_pkg::ORS_TOFF: begin
					if (cnt_q == cfg_q.toff_delay) begin
						st_q <= ors_pkg::ORS_FALL;
						cnt_q <= '0;
					end else if (tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ors_pkg::ORS_FALL: begin
					if (cnt_q == fall_n) begin
						st_q <= ors_pkg::ORS_OFF;
					end else if (tick) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ors_pkg::ORS_HIZ: begin
					cnt_q <= '0;
					// no retry: software or run line must cycle first
					if (!flt && off_req) begin
						st_q <= ors_pkg::ORS_OFF;
					end
				end
				default: st_q <= ors_pkg::ORS_OFF;
				endcase
			end
		end
	end

	a_run_start: assert property (
		st_q == ors_pkg::ORS_DLY && $past(st_q) == ors_pkg::ORS_OFF
		|-> $past(i_run_line))
		else $error("delay began without run");

	a_rise_skip: assert property (
		i_ce && st_q == ors_pkg::ORS_RISE && rise_skip &&
		!flt && !off_req |=> st_q == ors_pkg::ORS_WAIT)
		else $error("short rise did not skip");

	a_fault_hiz: assert property (
		i_ce && active && flt
		|=> st_q == ors_pkg::ORS_HIZ && !o_stage_en)
		else $error("fault did not three-state");

	// ton max counter runs from ramp start and holds at ton max until servo hand-over
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			lim_q <= '0;
		end else if (i_ce) begin
			if (st_q != ors_pkg::ORS_RISE && st_q != ors_pkg::ORS_WAIT) begin
				lim_q <= '0;
			end else if (tick && !lim_hit) begin
				lim_q <= lim_q + 1'b1;
			end
		end
	end

	// ramp target: vout * steps done / steps rising, base * steps left / steps falling; the divide is combinational,
	// traded for area since it is only needed at tick rate
	always_comb begin
		if (st_q == ors_pkg::ORS_RISE) begin
			den = rise_n;
			num = cnt_q;
		end else begin
			den = fall_n;
			num = fall_n - cnt_q;
		end
		prod = {{TW{1'b0}}, (st_q == ors_pkg::ORS_RISE ? cfg_q.vout
			: base_q)} * {{DW{1'b0}}, num};
		ramp = den == '0 ? '0 : DW'(prod / {{DW{1'b0}}, den});
	end

	assign servo_en = cfg_q.mode[ors_pkg::MODE_SERVO_BIT];
	assign srv_step = tick && srv_q == ors_pkg::SRV_W'(
		ors_pkg::SERVO_TICKS - 1);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			srv_q <= '0;
		end else if (i_ce) begin
			if (st_q != ors_pkg::ORS_ON || !servo_en || srv_step) begin
				srv_q <= '0;
			end else if (tick) begin
				srv_q <= srv_q + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dac_q <= '0;
			base_q <= '0;
		end else if (i_ce) begin
			case (st_q)
			ors_pkg::ORS_RISE: dac_q <= ramp;
			ors_pkg::ORS_WAIT: dac_q <= cfg_q.vout;
			ors_pkg::ORS_ON: begin
				if (servo_en && srv_step) begin
					if (i_sense.vout_low && dac_q != '1) begin
						dac_q <= dac_q + 1'b1;
					end else if (i_sense.vout_high && dac_q != '0) begin
						dac_q <= dac_q - 1'b1;
					end
				end
			end
			ors_pkg::ORS_TOFF: base_q <= dac_q;
			ors_pkg::ORS_FALL: dac_q <= ramp;
			default: dac_q <= '0;
			endcase
		end
	end
	assign o_dac = dac_q;

	a_servo_gate: assert property (
		i_ce && st_q == ors_pkg::ORS_ON && !servo_en
		##1 st_q == ors_pkg::ORS_ON |-> $stable(dac_q))
		else $error("dac moved with servo off");

	a_rise_zero: assert property (
		i_ce && st_q == ors_pkg::ORS_DLY &&
		!flt && !off_req && cnt_q == cfg_q.ton_delay
		|=> st_q == ors_pkg::ORS_RISE ##1 dac_q == '0)
		else $error("ramp did not start from zero");

	// conduction mode: discontinuous until servo hand-over or soft-off
	assign o_dcm = !(cfg_q.mode[ors_pkg::MODE_CCM_BIT] &&
		(st_q == ors_pkg::ORS_ON || st_q == ors_pkg::ORS_TOFF ||
		st_q == ors_pkg::ORS_FALL));
	assign o_low_gate_en = !(o_dcm && i_reverse_current);
	assign o_stage_en = st_q == ors_pkg::ORS_RISE ||
		st_q == ors_pkg::ORS_WAIT || st_q == ors_pkg::ORS_ON ||
		st_q == ors_pkg::ORS_TOFF || st_q == ors_pkg::ORS_FALL;
	assign o_sink_en = o_stage_en && !o_dcm;
	assign o_range_fine = cfg_q.mode[ors_pkg::MODE_RANGE_BIT];

	a_rise_dcm: assert property (
		st_q == ors_pkg::ORS_RISE
		|-> o_dcm && (!i_reverse_current || !o_low_gate_en))
		else $error("ramp not discontinuous");

	sequence s_fall_done;
		i_ce && !flt && st_q == ors_pkg::ORS_FALL && cnt_q == fall_n;
	endsequence
	property p_fall_end;
		s_fall_done |=> !o_sink_en && !o_stage_en;
	endproperty
	a_fall_end: assert property (p_fall_end)
		else $error("still sinking after fall");

	// power good deglitch: a change must persist PG_CYC cycles
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pg_q <= 1'b0;
			pg_cnt_q <= 16'h0000;
		end else if (i_ce) begin
			if (i_power_good_raw == pg_q) begin
				pg_cnt_q <= 16'h0000;
			end else if (pg_cnt_q == 16'(PG_CYC - 1)) begin
				pg_q <= i_power_good_raw;
				pg_cnt_q <= 16'h0000;
			end else begin
				pg_cnt_q <= pg_cnt_q + 16'h0001;
			end
		end
	end
	assign o_power_good_out = pg_q;

	a_pg_filter: assert property (
		i_ce && i_power_good_raw != pg_q && pg_cnt_q == 16'h0000
		|=> $stable(pg_q))
		else $error("power good passed a glitch");

endmodule

/* design/ors_pkg.sv */
/*
 * constants, register map and carrier types for the output ramp sequencer.
 * assumes a 125 MHz system clock and a 32-bit plain register port.
 */
package ors_pkg;

	// timing base
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned TICK_NS = 100000;
	localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned PG_FILT_NS = 60000;
	localparam int unsigned PG_FILT_CYC =
		(PG_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TICK_US = 100;
	localparam int unsigned RISE_MIN_US = 250;
	localparam int unsigned RISE_MIN_TICKS =
		(RISE_MIN_US + TICK_US - 1) / TICK_US;
	localparam int unsigned RAMP_MAX_MS = 1300;
	localparam int unsigned RAMP_MAX_TICKS = RAMP_MAX_MS * 1000 / TICK_US;
	localparam int unsigned SERVO_MS = 90;
	localparam int unsigned SERVO_TICKS = SERVO_MS * 1000 / TICK_US;

	// field widths
	localparam int unsigned TIME_W = 16;
	localparam int unsigned DAC_W = 12;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned SRV_W = 10;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h04;
	localparam logic [7:0] ADDR_TON_DELAY = 8'h08;
	localparam logic [7:0] ADDR_TON_RISE = 8'h0c;
	localparam logic [7:0] ADDR_TON_MAX = 8'h10;
	localparam logic [7:0] ADDR_TON_MAX_RESP = 8'h14;
	localparam logic [7:0] ADDR_TOFF_DELAY = 8'h18;
	localparam logic [7:0] ADDR_TOFF_FALL = 8'h1c;
	localparam logic [7:0] ADDR_VOUT = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	localparam logic [7:0] ADDR_DAC = 8'h28;

	// field positions
	localparam int unsigned CTRL_OP_BIT = 0;
	localparam int unsigned CTRL_FLT_RESP_BIT = 1;
	localparam int unsigned MODE_CCM_BIT = 0;
	localparam int unsigned MODE_RANGE_BIT = 1;
	localparam int unsigned MODE_SERVO_BIT = 6;

	// reset values
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] RESP_IGNORE = 8'h00;
	localparam logic [15:0] TIME_RST = 16'h0000;
	localparam logic [11:0] VOUT_RST = 12'h000;

	typedef enum logic [2:0] {
		ORS_OFF = 3'h0,
		ORS_DLY = 3'h1,
		ORS_RISE = 3'h3,
		ORS_WAIT = 3'h2,
		ORS_ON = 3'h6,
		ORS_TOFF = 3'h7,
		ORS_FALL = 3'h5,
		ORS_HIZ = 3'h4
	} ors_state_t;

	typedef struct packed {
		logic [1:0] ctrl;
		logic [7:0] mode;
		logic [TIME_W-1:0] ton_delay;
		logic [TIME_W-1:0] ton_rise;
		logic [TIME_W-1:0] ton_max;
		logic [7:0] ton_max_resp;
		logic [TIME_W-1:0] toff_delay;
		logic [TIME_W-1:0] toff_fall;
		logic [DAC_W-1:0] vout;
	} ors_cfg_t;

	typedef struct packed {
		logic vin_below_off;
		logic vin_above_on;
		logic uv_fault;
		logic oc_active;
		logic fault;
		logic vout_low;
		logic vout_high;
	} ors_sense_t;

endpackage

/* tb/ors_peer.sv */
/*
 * partner model: a second regulator sharing the run and time-base lines.
 * assumes both lines are open-drain with pull-ups, resolved by the bench.
 */
`timescale 1ns/100ps
module ors_peer #(
	parameter int unsigned PERIOD = 6
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ready,
	output logic o_run_oe,
	output logic o_tb_oe
);
	int unsigned cnt_q;

	// a sharer that is not ready keeps the common run line low
	assign o_run_oe = !i_ready;

	// free running and faster than the block, so it sets the common pace
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 0;
			o_tb_oe <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
			o_tb_oe <= (cnt_q == PERIOD - 1);
		end
	end
endmodule

/* tb/ors_top_bench.sv */
/*
 * self-checking bench: reset, run release, ramps, hand-over, servo,
 * soft-off, fault three-state, power-good filter and input lockout.
 * assumes ors_pkg, ors_top and ors_peer are compiled before it.
 */
`timescale 1ns/100ps
module ors_top_bench;
	localparam int unsigned PC = 4;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic init_done = 1'b0;
	ors_pkg::ors_sense_t sense = '0;
	logic fault_n = 1'b1;
	logic rev = 1'b0;
	logic pg_raw = 1'b0;
	logic peer_ready = 1'b0;
	logic [31:0] rdata;
	logic [11:0] dac;
	logic run_oe, tb_oe, peer_run_oe, peer_tb_oe;
	logic pg, dcm, lg, stg, snk, rng;
	// pull-ups: a released line reads high
	wire logic run_w = !(run_oe | peer_run_oe);
	wire logic tb_w = !(tb_oe | peer_tb_oe);
	int n_mismatch = 0;
	int tests_run = 0;
	int n;
	logic [31:0] rv;

	always #4 i_clk_sys = ~i_clk_sys;

	ors_top #(.TICK_CYC(8), .PG_CYC(PC)) i_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata), .i_init_done(init_done), .i_sense(sense),
		.i_run_line(run_w), .o_run_line(), .o_run_line_oe(run_oe),
		.i_time_base(tb_w), .o_time_base(), .o_time_base_oe(tb_oe),
		.i_fault_line_n(fault_n), .i_reverse_current(rev),
		.i_power_good_raw(pg_raw), .o_power_good_out(pg), .o_dac(dac),
		.o_dcm(dcm), .o_low_gate_en(lg), .o_stage_en(stg),
		.o_sink_en(snk), .o_range_fine(rng)
	);

	ors_peer #(.PERIOD(6)) i_peer (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ready(peer_ready),
		.o_run_oe(peer_run_oe), .o_tb_oe(peer_tb_oe)
	);

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk_sys);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge i_clk_sys);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask

	// leaves the cycle count in n
	task automatic wait_dac(input logic [11:0] v, input int lim);
		n = 0;
		while (dac !== v && n < lim) begin
			@(posedge i_clk_sys);
			#1 n++;
		end
	endtask

	task automatic summarize;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic t_reset;
		cmp(tb_oe, 1);
		rd(ors_pkg::ADDR_STATUS, rv);
		cmp(rv, 32'h03);
		rd(ors_pkg::ADDR_MODE, rv);
		cmp(rv, 32'h01);
		wr(ors_pkg::ADDR_STATUS, 32'h7f);
		rd(8'h2c, rv);
		cmp(rv, 32'h0);
		rd(ors_pkg::ADDR_STATUS, rv);
		cmp(rv, 32'h03);
	endtask

	task automatic t_release;
		@(posedge i_clk_sys);
		sense.vin_above_on <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		#1 cmp(run_oe, 1);
		@(posedge i_clk_sys);
		init_done <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		#1 cmp(run_oe, 0);
		cmp(run_w, 0);
		@(posedge i_clk_sys);
		peer_ready <= 1'b1;
		@(posedge i_clk_sys);
		#1 cmp(run_w, 1);
	endtask

	task automatic t_startup;
		wr(ors_pkg::ADDR_TON_DELAY, 32'h2);
		wr(ors_pkg::ADDR_TON_RISE, 32'h4);
		wr(ors_pkg::ADDR_VOUT, 32'h400);
		@(posedge i_clk_sys);
		sense.uv_fault <= 1'b1;
		wr(ors_pkg::ADDR_CTRL, 32'h1);
		for (int k = 1; k <= 4; k++) begin
			wait_dac(12'(k * 256), 100);
			cmp(dac, k * 256);
			cmp(dcm, 1);
			if (k == 1) cmp(n >= 12 && n <= 26, 1);
			else cmp(n, 6);
		end
		rd(ors_pkg::ADDR_STATUS, rv);
		cmp(rv & 32'h71, 32'h21);
		@(posedge i_clk_sys);
		rev <= 1'b1;
		#1 cmp(lg, 0);
		@(posedge i_clk_sys);
		rev <= 1'b0;
		sense.uv_fault <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		#1 cmp(dcm, 0);
		rd(ors_pkg::ADDR_STATUS, rv);
		cmp(rv & 32'h70, 32'h60);
		wr(ors_pkg::ADDR_MODE, 32'h00);
		repeat (2) @(posedge i_clk_sys);
		#1 cmp(dcm, 1);
		cmp(snk, 0);
		wr(ors_pkg::ADDR_MODE, 32'h01);
	endtask

	// peer ticks every 6 cycles, so a servo period is 900 * 6 cycles
	task automatic t_servo;
		@(posedge i_clk_sys);
		sense.vout_low <= 1'b1;
		repeat (5600) @(posedge i_clk_sys);
		#1 cmp(dac, 12'h400);
		// servo on this loop only; the peer never servoes
		wr(ors_pkg::ADDR_MODE, 32'h43);
		wait_dac(12'h401, 6000);
		cmp(dac, 12'h401);
		cmp(rng, 1);
		wait_dac(12'h402, 6000);
		cmp(n, 5400);
		@(posedge i_clk_sys);
		sense.vout_low <= 1'b0;
		sense.vout_high <= 1'b1;
		wait_dac(12'h401, 6000);
		cmp(dac, 12'h401);
		@(posedge i_clk_sys);
		sense.vout_high <= 1'b0;
		wr(ors_pkg::ADDR_MODE, 32'h01);
	endtask

	// soft-off from 0x401: floor of 0x401 * (4 - k) / 4
	task automatic t_softoff;
		wr(ors_pkg::ADDR_TOFF_DELAY, 32'h2);
		wr(ors_pkg::ADDR_TOFF_FALL, 32'h4);
		wr(ors_pkg::ADDR_CTRL, 32'h0);
		wait_dac(12'h300, 100);
		cmp(dac, 12'h300);
		cmp(n >= 12, 1);
		wait_dac(12'h200, 100);
		cmp(n, 6);
		cmp(snk, 1);
		wait_dac(12'h000, 100);
		cmp(dac, 12'h000);
		repeat (2) @(posedge i_clk_sys);
		#1 cmp(snk, 0);
		cmp(stg, 0);
	endtask

	task automatic t_skip_runlow;
		wr(ors_pkg::ADDR_TON_RISE, 32'h2);
		wr(ors_pkg::ADDR_CTRL, 32'h1);
		n = 0;
		while (dac === 12'h000 && n < 200) begin
			@(posedge i_clk_sys);
			#1 n++;
		end
		cmp(dac, 12'h400);
		@(posedge i_clk_sys);
		peer_ready <= 1'b0;
		wait_dac(12'h000, 200);
		cmp(dac, 12'h000);
		@(posedge i_clk_sys);
		peer_ready <= 1'b1;
	endtask

	// pass 0: external fault line, pass 1: internal fault
	task automatic t_fault;
		for (int c = 0; c < 2; c++) begin
			wr(ors_pkg::ADDR_CTRL, 32'h1);
			wait_dac(12'h400, 300);
			@(posedge i_clk_sys);
			if (c == 0) fault_n <= 1'b0;
			else sense.fault <= 1'b1;
			repeat (2) @(posedge i_clk_sys);
			#1 cmp(stg, c == 0);
			if (c == 0) wr(ors_pkg::ADDR_CTRL, 32'h3);
			repeat (2) @(posedge i_clk_sys);
			#1 cmp(stg, 0);
			@(posedge i_clk_sys);
			fault_n <= 1'b1;
			sense.fault <= 1'b0;
			wr(ors_pkg::ADDR_CTRL, 32'h0);
			repeat (3) @(posedge i_clk_sys);
		end
	endtask

	// 5-tick limit; pass 0 ignore response, pass 1 any other response
	task automatic t_limit;
		wr(ors_pkg::ADDR_TON_MAX, 32'h5);
		for (int c = 0; c < 2; c++) begin
			@(posedge i_clk_sys);
			sense.uv_fault <= 1'b1;
			wr(ors_pkg::ADDR_TON_MAX_RESP, c);
			wr(ors_pkg::ADDR_CTRL, 32'h1);
			wait_dac(12'h400, 300);
			rd(ors_pkg::ADDR_STATUS, rv);
			cmp(rv & 32'h70, 32'h20);
			repeat (40) @(posedge i_clk_sys);
			rd(ors_pkg::ADDR_STATUS, rv);
			cmp(rv & 32'h70, c ? 32'h20 : 32'h60);
			@(posedge i_clk_sys);
			sense.uv_fault <= 1'b0;
			repeat (2) @(posedge i_clk_sys);
			rd(ors_pkg::ADDR_STATUS, rv);
			cmp(rv & 32'h70, 32'h60);
			wr(ors_pkg::ADDR_CTRL, 32'h0);
			wait_dac(12'h000, 200);
		end
	endtask

	task automatic t_pgood;
		for (int i = 0; i < 2 * PC; i++) begin
			@(posedge i_clk_sys);
			pg_raw <= (i < PC - 1);
			#1 cmp(pg, 0);
		end
		@(posedge i_clk_sys);
		pg_raw <= 1'b1;
		n = 0;
		while (pg !== 1'b1 && n < 20) begin
			@(posedge i_clk_sys);
			#1 n++;
		end
		cmp(n >= PC && n <= PC + 1, 1);
	endtask

	// line stays pulled even after dropping below turn-off is over
	task automatic t_lockout;
		@(posedge i_clk_sys);
		sense.vin_above_on <= 1'b0;
		sense.vin_below_off <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		rv = 32'h1;
		for (int i = 0; i < 40; i++) begin
			@(posedge i_clk_sys);
			if (i == 10) sense.vin_below_off <= 1'b0;
			#1 rv = rv & {31'h0, tb_oe};
		end
		cmp(rv, 32'h1);
	endtask

	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		t_reset;
		t_release;
		t_startup;
		t_servo;
		t_softoff;
		t_skip_runlow;
		t_fault;
		t_limit;
		t_pgood;
		t_lockout;
		summarize;
	end

	initial begin
		#480000;
		n_mismatch++;
		summarize;
	end
endmodule
